// *** exv_map.vh ***
`ifndef EXV_MAP_VH
`define EXV_MAP_VH

`define EXV_NUM_W       6
`define EXV_NUM_RESET   6'h01
`define EXV_NUM_NMI     6'h02
`define EXV_NUM_HARD    6'h03
`define EXV_NUM_MEM     6'h04
`define EXV_NUM_BUS     6'h05
`define EXV_NUM_USAGE   6'h06
`define EXV_NUM_SVC     6'h0B
`define EXV_NUM_PSV     6'h0E
`define EXV_NUM_TICK    6'h0F
`define EXV_NUM_IRQ0    6'h10
`define EXV_NIRQ        33

`define EXV_PRI_RESET   5'h00
`define EXV_PRI_NMI     5'h01
`define EXV_PRI_HARD    5'h02
`define EXV_PRI_BIAS    5'h03

`define EXV_TBL_RST     32'h00000000
`define EXV_TBL_MIN     32'h00000080
`define EXV_TBL_MAX     32'h03FFFF80
`define EXV_TBL_ALIGN   32'hFFFFFF80
`define EXV_VEC_IRQ0    32'h00000040
`define EXV_VEC_SH      2

`define EXV_STATUS_W    9
`define EXV_STATUS_RST  9'h000
`define EXV_PRIO_RST    4'h0

`endif

// *** exv_pipe_model.sv ***
`timescale 1ns/100ps
`default_nettype none
module exv_pipe_model (
	input  wire logic i_clock,
	input  wire logic i_srst,
	input  wire logic i_entry_valid,
	input  wire logic        i_slow,
	input  wire logic [31:0] i_vector_addr,
	output logic             o_ack,
	output logic             o_ret,
	output logic      [31:0] o_handler
);
	logic [3:0] cnt_reg;
	logic       act_reg;
	// Ack only while offered, return only while active
	always @(posedge i_clock)
	begin
		o_ack <= 1'b0;
		o_ret <= 1'b0;
		cnt_reg <= cnt_reg + 4'h1;
		if (i_srst || (!act_reg && !i_entry_valid))
			cnt_reg <= 4'h0;
		if (i_srst)
		begin
			act_reg <= 1'b0;
			o_handler <= 32'h00000000;
		end
		else if (!act_reg && i_entry_valid && !o_ack && cnt_reg >= (i_slow ? 4'h7 : 4'h0))
		begin
			// Table words as software stores them: handler address with bit zero set
			o_handler <= i_vector_addr + 32'h00000001;
			o_ack <= 1'b1;
			act_reg <= 1'b1;
			cnt_reg <= 4'h0;
		end
		else if (act_reg && cnt_reg == 4'h3)
		begin
			o_ret <= 1'b1;
			act_reg <= 1'b0;
		end
	end
endmodule // exv_pipe_model
`default_nettype wire

// *** exv_prio_mem.v ***
`timescale 1ns/100ps
`default_nettype none
`include "exv_map.vh"

module exv_prio_mem #(
	parameter DW = 4,
	parameter AW = 6,
	parameter DEPTH = 49
) (
	input  wire          i_clock,
	input  wire          i_srst,
	input  wire          i_wr_en,
	input  wire [AW-1:0] i_wr_addr,
	input  wire [DW-1:0] i_wr_data,
	input  wire [AW-1:0] i_rd_addr,
	output reg  [DW-1:0] o_rd_data
);

	reg [DW-1:0] mem_reg [0:DEPTH-1];
	integer k;

	// Cleared on reset so unconfigured priorities read as zero
	always @(posedge i_clock)
	begin
		if (i_srst)
		begin
			for (k = 0; k < DEPTH; k = k + 1)
				mem_reg[k] <= `EXV_PRIO_RST;
			o_rd_data <= `EXV_PRIO_RST;
		end
		else
		begin
			if (i_wr_en)
				mem_reg[i_wr_addr] <= i_wr_data;
			o_rd_data <= mem_reg[i_rd_addr];
		end
	end

endmodule // exv_prio_mem
`default_nettype wire

// *** exv_resolver.v ***
`timescale 1ns/100ps
`default_nettype none
`include "exv_map.vh"

module exv_resolver #(
	parameter NIRQ = `EXV_NIRQ
) (
	input  wire                      i_clock,
	input  wire                      i_srst,
	input  wire [NIRQ-1:0]           i_irq_line,
	input  wire                      i_sw_pend_valid,
	input  wire [`EXV_NUM_W-1:0]     i_sw_pend_num,
	input  wire                      i_nmi,
	input  wire                      i_hardfault,
	input  wire                      i_memfault,
	input  wire                      i_busfault,
	input  wire                      i_bus_imprecise,
	input  wire                      i_usagefault,
	input  wire                      i_svc,
	input  wire                      i_pended_service_call,
	input  wire                      i_systick,
	input  wire                      i_priv,
	input  wire                      i_cfg_wr,
	input  wire [`EXV_NUM_W-1:0]     i_cfg_num,
	input  wire                      i_cfg_enable,
	input  wire [3:0]                i_cfg_prio,
	input  wire                      i_tbl_wr,
	input  wire [31:0]               i_tbl_wdata,
	input  wire                      i_entry_ack,
	input  wire                      i_exc_return,
	output wire                      o_entry_valid,
	output reg  [`EXV_NUM_W-1:0]     o_exc_num,
	output reg  [31:0]               o_vector_addr,
	output reg                       o_sync,
	output wire [31:0]               o_sp_addr,
	output reg  [31:0]               o_table_base,
	output reg  [`EXV_STATUS_W-1:0]  o_status_field,
	output reg                       o_cfg_err
);

	localparam NEXC = 16 + NIRQ;
	localparam [`EXV_NUM_W-1:0] LAST = NEXC - 1;
	localparam [3:0] ST_IDLE   = 4'h1;
	localparam [3:0] ST_HOLD   = 4'h2;
	localparam [3:0] ST_ENTRY  = 4'h4;
	localparam [3:0] ST_ACTIVE = 4'h8;

	reg  [3:0]            state_reg;
	reg  [3:0]            state_next;
	reg  [NEXC-1:0]       pend_reg;
	reg  [NEXC-1:0]       en_reg;
	reg  [NEXC-1:0]       set_vec;
	reg  [NEXC-1:0]       clr_vec;
	wire [NEXC-1:0]       cfg_mask;
	wire [NEXC-1:0]       live_vec;
	reg                   imprecise_reg;
	reg  [`EXV_NUM_W-1:0] scan_ptr_reg;
	reg  [`EXV_NUM_W-1:0] rd_num_reg;
	reg                   rd_vld_reg;
	wire [3:0]            rd_prio;
	reg                   best_vld_reg;
	reg  [`EXV_NUM_W-1:0] best_num_reg;
	reg  [4:0]            best_pri_reg;
	reg                   cand_vld_reg;
	reg  [`EXV_NUM_W-1:0] cand_num_reg;
	wire [4:0]            rd_eff;
	wire                  rd_elig;
	wire                  rd_better;
	wire                  commit;
	wire                  take;
	wire                  cfg_ok;
	wire                  tbl_ok;
	wire                  cand_sync;
	wire                  cand_fast;
	wire [31:0]           cand_vec;

	function cfg_able;
		input [`EXV_NUM_W-1:0] n;
		begin
			case (n)
				`EXV_NUM_MEM, `EXV_NUM_BUS, `EXV_NUM_USAGE, `EXV_NUM_SVC,
				`EXV_NUM_PSV, `EXV_NUM_TICK: cfg_able = 1'b1;
				default: cfg_able = (n >= `EXV_NUM_IRQ0);
			endcase
		end
	endfunction

	// Offset by three so that reset, -3, becomes zero and compares unsigned
	function [4:0] eff_prio;
		input [`EXV_NUM_W-1:0] n;
		input [3:0]            p;
		begin
			case (n)
				`EXV_NUM_RESET: eff_prio = `EXV_PRI_RESET;
				`EXV_NUM_NMI:   eff_prio = `EXV_PRI_NMI;
				`EXV_NUM_HARD:  eff_prio = `EXV_PRI_HARD;
				default:        eff_prio = {1'b0, p} + `EXV_PRI_BIAS;
			endcase
		end
	endfunction

	genvar g;
	generate
		for (g = 0; g < NEXC; g = g + 1)
		begin : g_mask
			localparam [`EXV_NUM_W-1:0] GN = g;
			assign cfg_mask[g] = cfg_able(GN);
		end
	endgenerate

	// Fixed exceptions cannot be switched off
	assign live_vec = pend_reg & (en_reg | ~cfg_mask);

	integer i;
	always @*
	begin
		set_vec = {NEXC{1'b0}};
		set_vec[`EXV_NUM_NMI] = i_nmi;
		set_vec[`EXV_NUM_HARD] = i_hardfault;
		set_vec[`EXV_NUM_MEM] = i_memfault;
		set_vec[`EXV_NUM_BUS] = i_busfault;
		set_vec[`EXV_NUM_USAGE] = i_usagefault;
		set_vec[`EXV_NUM_SVC] = i_svc;
		set_vec[`EXV_NUM_PSV] = i_pended_service_call;
		set_vec[`EXV_NUM_TICK] = i_systick;
		// Taken at any cycle, no tie to instruction flow
		for (i = 0; i < NIRQ; i = i + 1)
			set_vec[16 + i] = i_irq_line[i] |
				(i_sw_pend_valid && (i_sw_pend_num == 16 + i));
	end

	always @*
	begin
		clr_vec = {NEXC{1'b0}};
		if ((state_reg == ST_ENTRY) && i_entry_ack)
			clr_vec[o_exc_num] = 1'b1;
	end

	// Set wins over clear so a new request during entry stays pending
	always @(posedge i_clock)
	begin
		if (i_srst)
		begin
			pend_reg <= {{(NEXC - 2){1'b0}}, 2'b10};
			imprecise_reg <= 1'b0;
		end
		else
		begin
			pend_reg <= (pend_reg & ~clr_vec) | set_vec;
			if (i_busfault)
				imprecise_reg <= i_bus_imprecise;
		end
	end

	assign cfg_ok = i_cfg_wr && i_priv && (i_cfg_num < NEXC) && cfg_able(i_cfg_num);
	assign tbl_ok = (i_tbl_wdata >= `EXV_TBL_MIN) && (i_tbl_wdata <= `EXV_TBL_MAX);

	always @(posedge i_clock)
	begin
		if (i_srst)
		begin
			en_reg <= {NEXC{1'b1}};
			o_table_base <= `EXV_TBL_RST;
			o_cfg_err <= 1'b0;
		end
		else
		begin
			if (cfg_ok)
				en_reg[i_cfg_num] <= i_cfg_enable;
			if (i_tbl_wr && i_priv && tbl_ok)
				o_table_base <= i_tbl_wdata & `EXV_TBL_ALIGN;
			o_cfg_err <= (i_cfg_wr && !cfg_ok) || (i_tbl_wr && !(i_priv && tbl_ok));
		end
	end

	exv_prio_mem #(
		.DW    (4),
		.AW    (`EXV_NUM_W),
		.DEPTH (NEXC)
	) u_prio (
		.i_clock   (i_clock),
		.i_srst    (i_srst),
		.i_wr_en   (cfg_ok),
		.i_wr_addr (i_cfg_num),
		.i_wr_data (i_cfg_prio),
		.i_rd_addr (scan_ptr_reg),
		.o_rd_data (rd_prio)
	);

	// Sequential sweep trades entry latency for a single memory port
	assign rd_eff = eff_prio(rd_num_reg, rd_prio);
	assign rd_elig = rd_vld_reg && live_vec[rd_num_reg];
	assign rd_better = rd_elig && (!best_vld_reg || (rd_eff < best_pri_reg));
	assign commit = rd_vld_reg && (rd_num_reg == LAST);
	assign take = (state_reg == ST_IDLE) && cand_vld_reg && live_vec[cand_num_reg];

	always @(posedge i_clock)
	begin
		if (i_srst)
		begin
			scan_ptr_reg <= `EXV_NUM_RESET;
			rd_num_reg <= `EXV_NUM_RESET;
			rd_vld_reg <= 1'b0;
			best_vld_reg <= 1'b0;
			best_num_reg <= `EXV_NUM_RESET;
			best_pri_reg <= `EXV_PRI_RESET;
			cand_vld_reg <= 1'b0;
			cand_num_reg <= `EXV_NUM_RESET;
		end
		else
		begin
			scan_ptr_reg <= (scan_ptr_reg == LAST) ? `EXV_NUM_RESET : scan_ptr_reg + 6'h01;
			rd_num_reg <= scan_ptr_reg;
			rd_vld_reg <= 1'b1;
			if (commit)
			begin
				best_vld_reg <= 1'b0;
				cand_vld_reg <= rd_better | best_vld_reg;
				cand_num_reg <= rd_better ? rd_num_reg : best_num_reg;
			end
			else
			begin
				if (take)
					cand_vld_reg <= 1'b0;
				// Strict compare keeps the lowest number on a tie
				if (rd_better)
				begin
					best_vld_reg <= 1'b1;
					best_num_reg <= rd_num_reg;
					best_pri_reg <= rd_eff;
				end
			end
		end
	end

	// Reset is asynchronous yet gets no extra instruction slot
	assign cand_fast = cand_sync || (cand_num_reg == `EXV_NUM_RESET);
	assign cand_sync = (cand_num_reg == `EXV_NUM_HARD) ||
		(cand_num_reg == `EXV_NUM_MEM) || (cand_num_reg == `EXV_NUM_USAGE) ||
		(cand_num_reg == `EXV_NUM_SVC) ||
		((cand_num_reg == `EXV_NUM_BUS) && !imprecise_reg);

	assign cand_vec = (cand_num_reg >= `EXV_NUM_IRQ0) ?
		o_table_base + `EXV_VEC_IRQ0 +
			{24'h000000, cand_num_reg - `EXV_NUM_IRQ0, 2'b00} :
		o_table_base + {24'h000000, cand_num_reg, 2'b00};

	assign o_sp_addr = o_table_base;
	assign o_entry_valid = (state_reg == ST_ENTRY);

	always @*
	begin
		state_next = state_reg;
		case (state_reg)
			ST_IDLE:
				if (take)
					state_next = cand_fast ? ST_ENTRY : ST_HOLD;
			// One cycle slot for the instruction already in flight
			ST_HOLD:
				state_next = ST_ENTRY;
			ST_ENTRY:
				if (i_entry_ack)
					state_next = ST_ACTIVE;
			ST_ACTIVE:
				if (i_exc_return)
					state_next = ST_IDLE;
			default:
				state_next = ST_IDLE;
		endcase
	end

	always @(posedge i_clock)
	begin
		if (i_srst)
		begin
			state_reg <= ST_IDLE;
			o_exc_num <= `EXV_NUM_RESET;
			o_vector_addr <= `EXV_TBL_RST;
			o_sync <= 1'b0;
			o_status_field <= `EXV_STATUS_RST;
		end
		else
		begin
			state_reg <= state_next;
			if (take)
			begin
				o_exc_num <= cand_num_reg;
				o_vector_addr <= cand_vec;
				o_sync <= cand_sync;
			end
			if ((state_reg == ST_ENTRY) && i_entry_ack)
				o_status_field <= {3'b000, o_exc_num};
			else if ((state_reg == ST_ACTIVE) && i_exc_return)
				o_status_field <= `EXV_STATUS_RST;
		end
	end

endmodule // exv_resolver
`default_nettype wire

// *** exv_resolver_monitor.sv ***
`timescale 1ns/100ps
`default_nettype none
`include "exv_map.vh"
module exv_resolver_monitor (
	input wire logic                     i_clock,
	input wire logic                     i_srst,
	input wire logic                     i_priv,
	input wire logic                     i_tbl_wr,
	input wire logic [31:0]              i_tbl_wdata,
	input wire logic                     i_entry_ack,
	input wire logic                     o_entry_valid,
	input wire logic [`EXV_NUM_W-1:0]    o_exc_num,
	input wire logic [31:0]              o_vector_addr,
	input wire logic                     o_sync,
	input wire logic [31:0]              o_sp_addr,
	input wire logic [31:0]              o_table_base,
	input wire logic [`EXV_STATUS_W-1:0] o_status_field,
	input wire logic                     o_cfg_err
);
	default clocking @(posedge i_clock); endclocking
	default disable iff (i_srst);
	wire tbl_ok = i_priv && i_tbl_wdata >= `EXV_TBL_MIN && i_tbl_wdata <= `EXV_TBL_MAX;
	sequence s_offer;
		o_entry_valid && i_entry_ack;
	endsequence
	sequence s_shown;
		o_status_field == $past(o_exc_num);
	endsequence
	base_reset_a: assert property ($fell(i_srst) |-> o_table_base == `EXV_TBL_RST)
		else $error("table base not zero after reset");
	base_write_a: assert property (i_tbl_wr && tbl_ok
		|=> o_table_base == ($past(i_tbl_wdata) & `EXV_TBL_ALIGN)) else $error("base not moved");
	base_refuse_a: assert property (i_tbl_wr && !tbl_ok
		|=> o_cfg_err && $stable(o_table_base)) else $error("bad base write taken");
	sp_word_a: assert property (o_sp_addr == o_table_base)
		else $error("stack word not at base");
	sys_vec_a: assert property (o_entry_valid && o_exc_num < `EXV_NUM_IRQ0
		|-> o_vector_addr == o_table_base + {o_exc_num, 2'b00}) else $error("system vector");
	irq_vec_a: assert property (o_entry_valid && o_exc_num >= `EXV_NUM_IRQ0
		|-> o_vector_addr == o_table_base + `EXV_VEC_IRQ0 + {o_exc_num - `EXV_NUM_IRQ0, 2'b00})
		else $error("request vector");
	status_num_a: assert property (s_offer |=> s_shown)
		else $error("status field not entry number");
	sync_kind_a: assert property (o_entry_valid && o_exc_num != `EXV_NUM_BUS
		|-> o_sync == (o_exc_num inside {`EXV_NUM_HARD, `EXV_NUM_MEM, `EXV_NUM_USAGE,
		`EXV_NUM_SVC})) else $error("activation kind");
	reserved_a: assert property (o_entry_valid |-> !(o_exc_num inside {[7:10], 12, 13}))
		else $error("reserved number offered");
endmodule // exv_resolver_monitor
bind exv_resolver exv_resolver_monitor u_mon (.*);
`default_nettype wire

// *** exv_resolver_tb.sv ***
`timescale 1ns/100ps
`default_nettype none
module exv_resolver_tb;
	logic        i_clock = 1'b0;
	logic        i_srst = 1'b1;
	logic [32:0] irq = 33'h0;
	logic [7:0]  ev = 8'h00;
	logic        imp = 1'b0, priv = 1'b1, sw_v = 1'b0, cw = 1'b0, ce = 1'b1, tw = 1'b0;
	logic        slow = 1'b0;
	logic [5:0]  sw_n = 6'h00, cn = 6'h00;
	logic [3:0]  cp = 4'h0;
	logic [31:0] td = 32'h0, base = 32'h0;
	wire         ev_v, sync, cerr, ack, ret;
	wire  [5:0]  num;
	wire  [31:0] vec, sp, tb, hnd;
	wire  [8:0]  st;
	int          err_total = 0, compares = 0;
	always #10 i_clock = ~i_clock;
	exv_resolver dut (.i_clock(i_clock), .i_srst(i_srst), .i_irq_line(irq),
		.i_sw_pend_valid(sw_v), .i_sw_pend_num(sw_n), .i_nmi(ev[0]), .i_hardfault(ev[1]),
		.i_memfault(ev[2]), .i_busfault(ev[3]), .i_bus_imprecise(imp), .i_usagefault(ev[4]),
		.i_svc(ev[5]), .i_pended_service_call(ev[6]), .i_systick(ev[7]), .i_priv(priv), .i_cfg_wr(cw),
		.i_cfg_num(cn), .i_cfg_enable(ce), .i_cfg_prio(cp), .i_tbl_wr(tw), .i_tbl_wdata(td),
		.i_entry_ack(ack), .i_exc_return(ret), .o_entry_valid(ev_v), .o_exc_num(num),
		.o_vector_addr(vec), .o_sync(sync), .o_sp_addr(sp), .o_table_base(tb),
		.o_status_field(st), .o_cfg_err(cerr));
	exv_pipe_model pipe (.i_clock(i_clock), .i_srst(i_srst), .i_entry_valid(ev_v),
		.i_slow(slow), .i_vector_addr(vec), .o_ack(ack), .o_ret(ret), .o_handler(hnd));
	task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		compares++;
		if (seen !== exp)
		begin
			err_total++;
			$display("BAD %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic final_report();
		$display("compares %0d mismatches %0d", compares, err_total);
		if (err_total == 0 && compares > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	task automatic hit(input logic [7:0] e, input logic [32:0] q);
		@(negedge i_clock);
		ev = e;
		irq = q;
		@(negedge i_clock);
		ev = 8'h00;
		irq = 33'h0;
	endtask
	// Vector is base plus four per number, requests included
	task automatic take(input logic [5:0] n, input logic s);
		int k;
		for (k = 0; k < 400 && ev_v !== 1'b1; k++)
			@(negedge i_clock);
		check("offer", 32'(ev_v), 32'h1);
		if (k == 400)
			final_report();
		check("num", 32'(num), 32'(n));
		check("vec", vec, base + {24'h0, n, 2'b00});
		check("sync", 32'(sync), 32'(s));
		for (k = 0; k < 60 && st === 9'h000; k++)
			@(negedge i_clock);
		check("status", 32'(st), 32'(n));
		if (k == 60)
			final_report();
		check("handler", hnd, base + {24'h0, n, 2'b00} + 32'h1);
		for (k = 0; k < 60 && st !== 9'h000; k++)
			@(negedge i_clock);
		check("idle", 32'(st), 32'h0);
		if (k == 60)
			final_report();
	endtask
	task automatic cfg(input logic [5:0] n, input logic e, input logic [3:0] p,
		input logic pr, input logic x);
		@(negedge i_clock);
		{cw, cn, ce, cp, priv} = {1'b1, n, e, p, pr};
		@(negedge i_clock);
		{cw, priv} = 2'b01;
		check("cfg_err", 32'(cerr), 32'(x));
	endtask
	task automatic tbl(input logic [31:0] d, input logic pr, input logic [31:0] b,
		input logic x);
		@(negedge i_clock);
		{tw, td, priv} = {1'b1, d, pr};
		@(negedge i_clock);
		{tw, priv} = 2'b01;
		base = b;
		check("base", tb, b);
		check("sp", sp, b);
		check("tbl_err", 32'(cerr), 32'(x));
	endtask
	task automatic t_boot();
		check("base", tb, 32'h0);
		take(6'h01, 1'b0);
		$display("t_boot done");
	endtask
	task automatic t_prio();
		cfg(6'h02, 1'b0, 4'h0, 1'b1, 1'b1);
		cfg(6'h03, 1'b0, 4'h0, 1'b1, 1'b1);
		cfg(6'h08, 1'b1, 4'h0, 1'b1, 1'b1);
		cfg(6'h11, 1'b0, 4'h0, 1'b0, 1'b1);
		cfg(6'h10, 1'b0, 4'h0, 1'b1, 1'b0);
		cfg(6'h0F, 1'b1, 4'h2, 1'b1, 1'b0);
		hit(8'hA3, 33'h100000003);
		take(6'h02, 1'b0);
		take(6'h03, 1'b1);
		take(6'h0B, 1'b1);
		take(6'h11, 1'b0);
		take(6'h30, 1'b0);
		take(6'h0F, 1'b0);
		cfg(6'h10, 1'b1, 4'h0, 1'b1, 1'b0);
		take(6'h10, 1'b0);
		$display("t_prio done");
	endtask
	task automatic t_tbl();
		tbl(32'h0, 1'b1, 32'h0, 1'b1);
		tbl(32'h03FFFFC0, 1'b1, 32'h0, 1'b1);
		tbl(32'h200, 1'b0, 32'h0, 1'b1);
		tbl(32'h03FFFF80, 1'b1, 32'h03FFFF80, 1'b0);
		tbl(32'h2A5, 1'b1, 32'h280, 1'b0);
		hit(8'h5C, 33'h0);
		take(6'h04, 1'b1);
		take(6'h05, 1'b1);
		take(6'h06, 1'b1);
		take(6'h0E, 1'b0);
		imp = 1'b1;
		hit(8'h08, 33'h0);
		imp = 1'b0;
		take(6'h05, 1'b0);
		$display("t_tbl done");
	endtask
	task automatic t_sw();
		slow = 1'b1;
		@(negedge i_clock);
		{sw_v, sw_n} = {1'b1, 6'h14};
		@(negedge i_clock);
		sw_v = 1'b0;
		take(6'h14, 1'b0);
		$display("t_sw done");
	endtask
	initial
	begin
		repeat (12) @(negedge i_clock);
		i_srst = 1'b0;
		t_boot();
		t_prio();
		t_tbl();
		t_sw();
		final_report();
	end
endmodule // exv_resolver_tb
`default_nettype wire
